// File: bench/ctlc_mem_model.sv
// behavioural main memory that answers line fetches of the cache
`timescale 1ns/10ps
`default_nettype none
`include "ctlc_params.svh"

module ctlc_mem_model (
  // clock
  input  wire logic                   core_clk,
  // fetch request from the cache
  input  wire logic                   memReq,
  input  wire logic [`CTLC_BLK_W-1:0] memBlock,
  // answer delay chosen by the bench, 0 to 3 cycles
  input  wire logic [1:0]             memLat,
  // line answer and bookkeeping for the bench
  output var ctlc_pkg::ctlc_mem_t     memRsp,
  output var int                      memFetches,
  output logic [`CTLC_BLK_W-1:0]      memLastBlk
);
  logic [1:0] waitCnt;  // cycles the request has waited

  initial begin
    memRsp = '0;
    memFetches = 0;
    memLastBlk = '0;
    waitCnt = 2'h0;
  end

  // answer on the falling edge so the cache samples a settled line
  always @(negedge core_clk) begin
    if (memReq === 1'b1 && memRsp.ack !== 1'b1 && waitCnt >= memLat) begin
      // whole line in one pulse, byte 0 in the low bits
      memRsp.ack = 1'b1;
      memRsp.data = {memBlock[7:0] ^ 8'ha5, memBlock[15:8], 2'h2,
                     memBlock[21:16], memBlock[7:0] + 8'h3c};
      memFetches++;
      memLastBlk = memBlock;
    end else begin
      // idle data inverts every cycle, so it differs from the last line on odd idle cycles
      memRsp.ack = 1'b0;
      memRsp.data = ~memRsp.data;
      waitCnt = (memReq === 1'b1) ? waitCnt + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// File: bench/ctlc_top_tb.sv
// self-checking bench of the cache tag lookup controller
`timescale 1ns/10ps
`default_nettype none
`include "ctlc_params.svh"

module ctlc_top_tb;
  logic                   core_clk;    // 10 MHz core clock
  logic                   rst_b;       // active-low reset
  ctlc_pkg::ctlc_org_t    cfgOrg;      // organisation under test
  ctlc_pkg::ctlc_pol_t    cfgPolicy;   // victim policy under test
  ctlc_pkg::ctlc_req_t    procReq;     // processor request
  logic                   reqReady;
  logic                   rspValid;
  ctlc_pkg::ctlc_rsp_t    rspOut;
  logic                   memReq;
  logic [`CTLC_BLK_W-1:0] memBlock;
  ctlc_pkg::ctlc_mem_t    memRsp;
  logic [1:0]             memLat;      // memory delay per access
  int                     memFetches;  // lines fetched so far
  logic [`CTLC_BLK_W-1:0] memLastBlk;  // block of the last fetch
  int                     miscompares;
  int                     totalChecks;
  int                     seed;
  logic [`CTLC_BLK_W-1:0] refBlk [2][int];  // reference block per way
  logic                   refBit [int];     // reference victim bit
  logic [`CTLC_BLK_W-1:0] faBlk [`CTLC_FA_LINES];
  logic                   faVld [`CTLC_FA_LINES];
  int                     faPtr;       // round-robin slot of next fill
  int                     wayCnt [2];  // fills seen per way
  logic [7:0]             lfsrRef;     // reference random source
  logic [31:0]            corner [8] = '{32'h0012ffe8, 32'h0012ffe8,
    32'h0012ffeb, 32'h0044ffe8, 32'h00127fe9, 32'h0012ffea,
    32'h0112ffe8, 32'h0013ffe8};

  ctlc_top dut_u (.core_clk(core_clk), .rst_b(rst_b), .cfgOrg(cfgOrg),
    .cfgPolicy(cfgPolicy), .procReq(procReq), .reqReady(reqReady),
    .rspValid(rspValid), .rspOut(rspOut), .memReq(memReq),
    .memBlock(memBlock), .memRsp(memRsp));

  ctlc_mem_model mem_u (.core_clk(core_clk), .memReq(memReq),
    .memBlock(memBlock), .memLat(memLat), .memRsp(memRsp),
    .memFetches(memFetches), .memLastBlk(memLastBlk));

  // free-running clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // reference random source: same taps and seed as the cache's
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      lfsrRef <= `CTLC_LFSR_SEED;
    else
      lfsrRef <= {lfsrRef[6:0],
                  lfsrRef[7] ^ lfsrRef[5] ^ lfsrRef[4] ^ lfsrRef[3]};
  end

  // line content the memory model hands out for a block
  function automatic logic [31:0] lineOf(input logic [21:0] b);
    return {b[7:0] ^ 8'ha5, b[15:8], 2'h2, b[21:16], b[7:0] + 8'h3c};
  endfunction

  // random address over few indices and tags, some not for the cache
  function automatic logic [31:0] randAddr();
    logic [31:0] r;
    r = $random(seed);
    return {(r[10:8] == 3'h0) ? 8'h5a : 8'h00, r[1:0], 6'h00,
            r[2], 10'h3ff, r[5:3], r[7:6]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, g);
    totalChecks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // reset, then set the organisation while reset is held
  task automatic restart(input ctlc_pkg::ctlc_org_t o,
                         input ctlc_pkg::ctlc_pol_t p);
    @(negedge core_clk);
    rst_b = 1'b0;
    @(negedge core_clk);
    cfgOrg = o;
    cfgPolicy = p;
    refBlk[0].delete();
    refBlk[1].delete();
    refBit.delete();
    faPtr = 0;
    wayCnt = '{0, 0};
    foreach (faVld[k]) faVld[k] = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("rstReady", 1'b1, reqReady);
    chk("rstMemReq", 1'b0, memReq);
    rst_b = 1'b1;
  endtask

  // one read: predict, drive, wait for the answer, compare, update
  task automatic access(input logic [31:0] a);
    logic [`CTLC_BLK_W-1:0] b;
    logic [31:0] ln;
    logic cl, h, w;
    int i, n, f;
    b = a[23:2];
    ln = lineOf(b);
    cl = (a[31:24] == 8'h00);
    i = (cfgOrg == ctlc_pkg::ORG_DM) ? int'(a[15:2]) : int'(a[14:2]);
    h = 1'b0;
    w = 1'b0;
    // only the tag part of the stored block can differ at one index
    if (cfgOrg == ctlc_pkg::ORG_FA) begin
      for (n = 0; n < `CTLC_FA_LINES; n++)
        if (faVld[n] && faBlk[n] === b) h = 1'b1;
    end else begin
      for (n = 0; n < 2; n++)
        if (refBlk[n].exists(i) && refBlk[n][i] === b) begin
          h = 1'b1;
          w = n[0];
        end
    end
    h = h & cl;
    f = memFetches;
    memLat = 2'($random(seed));
    @(negedge core_clk);
    procReq.valid = 1'b1;
    procReq.addr = a;
    // hold the request until an edge that finds the cache ready
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    procReq.valid = 1'b0;
    procReq.addr = 32'($random(seed));
    n = 0;
    while (rspValid !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    chk("rspValid", 1'b1, rspValid);
    chk("claimed", cl, rspOut.claimed);
    chk("hit", h, rspOut.hit);
    chk("data", cl ? ln[a[1:0]*8 +: 8] : 8'h00, rspOut.data);
    chk("fetches", f + (cl & ~h), memFetches);
    if (cl && !h) begin
      chk("memBlock", b, memLastBlk);
      if (cfgOrg == ctlc_pkg::ORG_DM)
        refBlk[0][i] = b;
      else if (cfgOrg == ctlc_pkg::ORG_FA) begin
        // random slot: low 7 source bits as they stood at the fill edge
        n = (cfgPolicy == ctlc_pkg::POL_RAND) ? int'(lfsrRef[7:1]) : faPtr;
        faBlk[n] = b;
        faVld[n] = 1'b1;
        faPtr = (faPtr + 1) % `CTLC_FA_LINES;
      end else begin
        // random way: source bit 0 as it stood at the fill edge
        w = (cfgPolicy == ctlc_pkg::POL_RAND) ? lfsrRef[1] :
            (refBit.exists(i) ? refBit[i] : 1'b0);
        refBlk[w][i] = b;
        refBit[i] = ~w;
        wayCnt[w]++;
      end
    end else if (h && cfgOrg == ctlc_pkg::ORG_SA2 &&
                 cfgPolicy == ctlc_pkg::POL_LRU)
      refBit[i] = ~w;
    if (cl) chk("way", w, rspOut.way);
  endtask

  // give up if the run takes far longer than planned
  initial begin
    #3000000;
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    procReq = '0;
    memLat = 2'h0;
    cfgOrg = ctlc_pkg::ORG_DM;
    cfgPolicy = ctlc_pkg::POL_LRU;
    seed = 90;
    miscompares = 0;
    totalChecks = 0;
    for (int m = 0; m < 4; m++) begin
      // direct mapped, then two-way with each victim policy
      restart((m == 0) ? ctlc_pkg::ORG_DM : ctlc_pkg::ORG_SA2,
              ctlc_pkg::ctlc_pol_t'((m == 0) ? 0 : m - 1));
      foreach (corner[k]) access(corner[k]);
      repeat (60) access(randAddr());
    end
    chk("bothWays", 1'b1, wayCnt[0] > 0 && wayCnt[1] > 0);
    // fully associative: fill all lines, hit them all, then evict
    restart(ctlc_pkg::ORG_FA, ctlc_pkg::POL_LRU);
    for (int k = 0; k < 2 * `CTLC_FA_LINES; k++)
      access({8'h00, 22'((k % `CTLC_FA_LINES) * 977), 2'(k)});
    access({8'h00, 22'h3fffff, 2'h1});
    access({8'h00, 22'h000000, 2'h2});
    // fully associative with random slots over a small block pool
    restart(ctlc_pkg::ORG_FA, ctlc_pkg::POL_RAND);
    repeat (40) access(randAddr());
    end_of_test();
  end
endmodule
`default_nettype wire

// File: src/ctlc_params.svh
// field positions, sizes and reset values of the cache tag lookup controller
// How it works
// - direct-mapped: one tag compare at indexed line
// - 14-bit line index, 2-bit byte select
// - direct-mapped line keeps an 8-bit tag
// - top 8 address bits select the cache
// - tag match returns byte, no memory access
// - miss: fetch line, refill, new tag, deliver
// - direct-mapped and two-way: only tag bits compared, index not stored
// - two-way: half the locations, tag gains bit
// - two-way: two compares, report hitting set
// - refill may land in either set
// - victim by LRU, FIFO or random
// - LRU bits per index, updated on every hit and refill
// - fully associative: 128 full block addresses compared
`ifndef CTLC_PARAMS_SVH
`define CTLC_PARAMS_SVH

`define CTLC_SEL_HI     31
`define CTLC_SEL_LO     24
`define CTLC_SEL_W      8
`define CTLC_SEL_CODE   8'h00
`define CTLC_TAG_HI     23
`define CTLC_DM_TAG_LO  16
`define CTLC_DM_IDX_HI  15
`define CTLC_SA_TAG_LO  15
`define CTLC_SA_IDX_HI  14
`define CTLC_IDX_LO     2
`define CTLC_DM_IDX_W   14
`define CTLC_SA_IDX_W   13
`define CTLC_TAG_W      9
`define CTLC_BLK_W      22
`define CTLC_LINE_W     32
`define CTLC_DM_LINES   16384
`define CTLC_SA_SETS    8192
`define CTLC_FA_LINES   128
`define CTLC_FA_IDX_W   7
`define CTLC_LFSR_SEED  8'h01

`endif

// File: src/ctlc_pkg.sv
// types shared by the cache tag lookup controller
package ctlc_pkg;

  // cache organisation
  typedef enum logic [1:0] {ORG_DM, ORG_SA2, ORG_FA} ctlc_org_t;

  // victim choice
  typedef enum logic [1:0] {POL_LRU, POL_FIFO, POL_RAND} ctlc_pol_t;

  // controller sequence
  typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_FILL} ctlc_state_t;

  // processor request
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } ctlc_req_t;

  // answer to the processor
  typedef struct packed {
    logic       claimed;
    logic       hit;
    logic       way;
    logic [7:0] data;
  } ctlc_rsp_t;

  // line returned by main memory
  typedef struct packed {
    logic        ack;
    logic [31:0] data;
  } ctlc_mem_t;

endpackage

// File: src/ctlc_top.sv
// tag directory and lookup sequencer of the cache
`timescale 1ns/10ps
`default_nettype none
`include "ctlc_params.svh"

module ctlc_top #(
  parameter logic [`CTLC_SEL_W-1:0] SEL_CODE = `CTLC_SEL_CODE,
  parameter int                     FA_LINES = `CTLC_FA_LINES
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // configuration, hold steady between resets
  input  wire ctlc_pkg::ctlc_org_t  cfgOrg,
  input  wire ctlc_pkg::ctlc_pol_t  cfgPolicy,
  // processor side
  input  wire ctlc_pkg::ctlc_req_t  procReq,
  output logic                      reqReady,
  output logic                      rspValid,
  output var ctlc_pkg::ctlc_rsp_t   rspOut,
  // main memory side
  output logic                      memReq,
  output logic [`CTLC_BLK_W-1:0]    memBlock,
  input  wire ctlc_pkg::ctlc_mem_t  memRsp
);

  localparam int LINES = `CTLC_DM_LINES;

  ctlc_pkg::ctlc_state_t stateQ;
  logic                  readyQ, rspValidQ, memReqQ;
  ctlc_pkg::ctlc_rsp_t   rspQ;
  logic [31:0]           addrQ;                 // latched request address
  logic [`CTLC_FA_IDX_W-1:0] faPtrQ;            // fully assoc fill order

  // storage: tags, valid bits and lines
  logic [`CTLC_TAG_W-1:0]  tagMem   [LINES];
  logic                    validMem [LINES];
  logic [`CTLC_LINE_W-1:0] dataMem  [LINES];
  logic [`CTLC_BLK_W-1:0]  faBlk    [FA_LINES]; // full block address
  logic                    faValid  [FA_LINES];
  logic [`CTLC_LINE_W-1:0] faData   [FA_LINES];

  // address fields; direct-mapped and two-way tags leave out index bits since position implies them, fully assoc stores them
  wire logic                        takeReq  = procReq.valid && readyQ;
  wire logic                        claimed  =
    addrQ[`CTLC_SEL_HI:`CTLC_SEL_LO] == SEL_CODE;
  wire logic [`CTLC_TAG_W-1:0]      dmTag    =
    {1'b0, addrQ[`CTLC_TAG_HI:`CTLC_DM_TAG_LO]};
  wire logic [`CTLC_TAG_W-1:0]      saTag    =
    addrQ[`CTLC_TAG_HI:`CTLC_SA_TAG_LO];
  wire logic [`CTLC_DM_IDX_W-1:0]   dmLoc    =
    addrQ[`CTLC_DM_IDX_HI:`CTLC_IDX_LO];
  wire logic [`CTLC_SA_IDX_W-1:0]   saIdx    =
    addrQ[`CTLC_SA_IDX_HI:`CTLC_IDX_LO];
  wire logic [`CTLC_DM_IDX_W-1:0]   saLoc0   = {1'b0, saIdx};
  wire logic [`CTLC_DM_IDX_W-1:0]   saLoc1   = {1'b1, saIdx};
  wire logic [`CTLC_BLK_W-1:0]      blkAddr  =
    addrQ[`CTLC_TAG_HI:`CTLC_IDX_LO];
  wire logic [4:0]                  bytePos  = {addrQ[1:0], 3'b000};

  // compares: tag bits only
  wire logic dmHit  = validMem[dmLoc] && tagMem[dmLoc] == dmTag;
  wire logic saHit0 = validMem[saLoc0] && tagMem[saLoc0] == saTag;
  wire logic saHit1 = validMem[saLoc1] && tagMem[saLoc1] == saTag;

  // fully associative compare against every entry
  logic [FA_LINES-1:0] faHitVec;
  for (genvar i = 0; i < FA_LINES; i++) begin : g_faCmp
    assign faHitVec[i] = faValid[i] && faBlk[i] == blkAddr;
  end

  // lowest matching entry; only one can match while fills are on misses
  logic [`CTLC_FA_IDX_W-1:0] faHitIdx;
  always_comb begin
    faHitIdx = '0;
    for (int i = FA_LINES - 1; i >= 0; i--) begin
      if (faHitVec[i]) begin
        faHitIdx = i[`CTLC_FA_IDX_W-1:0];
      end
    end
  end

  // organisation select
  wire logic isDm = cfgOrg == ctlc_pkg::ORG_DM;
  wire logic isSa = cfgOrg == ctlc_pkg::ORG_SA2;
  wire logic anyHit = isDm ? dmHit :
                      isSa ? (saHit0 | saHit1) : (|faHitVec);
  wire logic hitWay = isSa && saHit1;
  wire logic [`CTLC_LINE_W-1:0] hitLine =
    isDm ? dataMem[dmLoc] :
    isSa ? dataMem[hitWay ? saLoc1 : saLoc0] : faData[faHitIdx];
  wire logic [7:0] hitByte = hitLine[bytePos +: 8];

  // victim choice and refill location
  logic       victimWay;
  logic [7:0] randBits;
  wire logic fillDone = stateQ == ctlc_pkg::ST_FILL && memRsp.ack;
  wire logic lookHit  = stateQ == ctlc_pkg::ST_LOOKUP && claimed && anyHit;
  wire logic [`CTLC_DM_IDX_W-1:0] fillLoc =
    isSa ? {victimWay, saIdx} : dmLoc;
  wire logic [`CTLC_FA_IDX_W-1:0] faVictim =
    (cfgPolicy == ctlc_pkg::POL_RAND) ? randBits[`CTLC_FA_IDX_W-1:0]
                                      : faPtrQ;
  wire logic [7:0] fillByte = memRsp.data[bytePos +: 8];

  ctlc_victim_sel #(
    .SETS (`CTLC_SA_SETS)
  ) u_victim (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .policy    (cfgPolicy),
    .idx       (saIdx),
    .touch     (isSa && (lookHit || fillDone)),
    .touchWay  (fillDone ? victimWay : hitWay),
    .advance   (isSa && fillDone),
    .victimWay (victimWay),
    .randBits  (randBits)
  );

  // sequencer: idle -> lookup -> (answer | fill -> answer)
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ    <= ctlc_pkg::ST_IDLE;
      readyQ    <= 1'b1;
      rspValidQ <= 1'b0;
      rspQ      <= '0;
      memReqQ   <= 1'b0;
      addrQ     <= '0;
    end else begin
      rspValidQ <= 1'b0;
      case (stateQ)
        ctlc_pkg::ST_IDLE: begin
          if (takeReq) begin
            addrQ  <= procReq.addr;
            readyQ <= 1'b0;
            stateQ <= ctlc_pkg::ST_LOOKUP;
          end
        end
        ctlc_pkg::ST_LOOKUP: begin
          if (!claimed || anyHit) begin
            // other memory or hit: answer now, memory untouched
            rspValidQ <= 1'b1;
            rspQ      <= '{claimed, claimed, hitWay,
                           claimed ? hitByte : 8'h00};
            readyQ    <= 1'b1;
            stateQ    <= ctlc_pkg::ST_IDLE;
          end else begin
            memReqQ <= 1'b1;
            stateQ  <= ctlc_pkg::ST_FILL;
          end
        end
        ctlc_pkg::ST_FILL: begin
          if (memRsp.ack) begin
            // byte forwarded from the arriving line, saves a lookup cycle
            memReqQ   <= 1'b0;
            rspValidQ <= 1'b1;
            rspQ      <= '{1'b1, 1'b0, isSa && victimWay, fillByte};
            readyQ    <= 1'b1;
            stateQ    <= ctlc_pkg::ST_IDLE;
          end
        end
        default: begin
          stateQ <= ctlc_pkg::ST_IDLE;
          readyQ <= 1'b1;
        end
      endcase
    end
  end

  // valid bits: cleared at reset, set by refill
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < LINES; i++) validMem[i] <= 1'b0;
      for (int i = 0; i < FA_LINES; i++) faValid[i] <= 1'b0;
      faPtrQ <= '0;
    end else if (fillDone) begin
      if (cfgOrg == ctlc_pkg::ORG_FA) begin
        faValid[faVictim] <= 1'b1;
        faPtrQ            <= faPtrQ + 1'b1;
      end else begin
        validMem[fillLoc] <= 1'b1;
      end
    end
  end

  // tags and lines carry no reset; valid bits guard them
  always_ff @(posedge core_clk) begin
    if (fillDone) begin
      if (cfgOrg == ctlc_pkg::ORG_FA) begin
        faBlk[faVictim]  <= blkAddr;
        faData[faVictim] <= memRsp.data;
      end else begin
        tagMem[fillLoc]  <= isSa ? saTag : dmTag;
        dataMem[fillLoc] <= memRsp.data;
      end
    end
  end

  assign reqReady = readyQ;
  assign rspValid = rspValidQ;
  assign rspOut   = rspQ;
  assign memReq   = memReqQ;
  assign memBlock = blkAddr;

  // checks
  a_decode_miss: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    stateQ == ctlc_pkg::ST_LOOKUP && !claimed |=>
      rspValid && !rspOut.claimed && !memReq)
    else $error("unclaimed access not answered");
  a_hit_no_mem: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    lookHit |=> rspValid && rspOut.hit && rspOut.data == $past(hitByte)
      && !memReq)
    else $error("hit touched memory or bad byte");
  a_miss_fetch: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    stateQ == ctlc_pkg::ST_LOOKUP && claimed && !anyHit |=>
      memReq && !rspValid)
    else $error("miss did not fetch");
  a_refill_tag: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    fillDone && cfgOrg != ctlc_pkg::ORG_FA |=>
      validMem[$past(fillLoc)] && anyHit && rspValid && !rspOut.hit)
    else $error("refill left line missing");
  a_dm_one_way: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    rspValid && isDm |-> !rspOut.way)
    else $error("direct map reported set 1");
  a_set_report: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    lookHit && isSa |=> rspOut.way == $past(saHit1))
    else $error("wrong set reported");
  a_lru_points: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    lookHit && isSa && cfgPolicy == ctlc_pkg::POL_LRU |=>
      victimWay != $past(hitWay))
    else $error("lru not updated");
  a_fa_refill: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    fillDone && cfgOrg == ctlc_pkg::ORG_FA |=> faHitVec != '0)
    else $error("fully assoc refill not found");
  a_ready_busy: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    takeReq |=> !reqReady ##1 (reqReady || memReq))
    else $error("ready during lookup");

  c_hit:   cover property (@(posedge core_clk) disable iff (!rst_b) lookHit);
  c_fill:  cover property (@(posedge core_clk) disable iff (!rst_b) fillDone);
  c_set1:  cover property (@(posedge core_clk) disable iff (!rst_b)
    lookHit && isSa && saHit1);
  c_other: cover property (@(posedge core_clk) disable iff (!rst_b)
    stateQ == ctlc_pkg::ST_LOOKUP && !claimed);

endmodule
`default_nettype wire

// File: src/ctlc_victim_sel.sv
// per-index victim choice for the two-way organisation
`timescale 1ns/10ps
`default_nettype none
`include "ctlc_params.svh"

module ctlc_victim_sel #(
  parameter int SETS = `CTLC_SA_SETS
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  // control
  input  wire ctlc_pkg::ctlc_pol_t       policy,
  input  wire logic [`CTLC_SA_IDX_W-1:0] idx,
  input  wire logic                      touch,
  input  wire logic                      touchWay,
  input  wire logic                      advance,
  // choice
  output logic                           victimWay,
  output logic [7:0]                     randBits
);

  logic       lruQ  [SETS];  // way to overwrite next, per index
  logic       fifoQ [SETS];  // next way in fill order, per index
  logic [7:0] lfsrQ;         // free-running pseudo random source
  logic       lfsrFb;

  assign lfsrFb   = lfsrQ[7] ^ lfsrQ[5] ^ lfsrQ[4] ^ lfsrQ[3];
  assign randBits = lfsrQ;
  // victim per selected policy
  assign victimWay = (policy == ctlc_pkg::POL_LRU)  ? lruQ[idx] :
                     (policy == ctlc_pkg::POL_FIFO) ? fifoQ[idx] :
                     lfsrQ[0];

  // usage bits point away from the way just used
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SETS; i++) begin
        lruQ[i]  <= 1'b0;
        fifoQ[i] <= 1'b0;
      end
    end else begin
      if (touch) begin
        lruQ[idx] <= ~touchWay;
      end
      if (advance) begin
        fifoQ[idx] <= ~fifoQ[idx];
      end
    end
  end

  // lfsr runs every cycle so random picks do not repeat per access
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lfsrQ <= `CTLC_LFSR_SEED;
    end else begin
      lfsrQ <= {lfsrQ[6:0], lfsrFb};
    end
  end

endmodule
`default_nettype wire
